// ### common/tio_pkg.sv
// Purpose: constants and types of the timed i/o port block
// Assumes: 32-bit apb, one clock
// Notes:   register offsets are byte addresses
package tio_pkg;

  localparam int DATA_W = 32;   // transfer register width
  localparam int CB_N   = 6;    // clock blocks per tile
  localparam int CNT_W  = 16;   // port counter width

  // reference rate of clock block 0 (block 0 ticks every bus clock)
  localparam int REF_MHZ = 100;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_DATA   = 8'h04;
  localparam logic [7:0] OFS_COND   = 8'h08;
  localparam logic [7:0] OFS_TIME   = 8'h0c;
  localparam logic [7:0] OFS_COUNT  = 8'h10;
  localparam logic [7:0] OFS_STAMP  = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_CB     = 8'h20; // 0x20 + 4*n, n = 1..5

  // status bit positions
  localparam int ST_RXV  = 0;
  localparam int ST_TXF  = 1;
  localparam int ST_BUSY = 2;

  // control register, bit 0 is enable
  typedef struct packed {
    logic [2:0] cb_sel;        // clock block feeding the port
    logic       timed;         // wait for counter == time
    logic       cond_en;       // input waits for pin == cond
    logic       strobe_out_en; // drive strobe_out with data
    logic       strobe_in_en;  // qualify input by strobe_in
    logic       open_coll;     // open-collector output
    logic       dir_out;       // 1 output, 0 input
    logic       enable;
  } tio_ctrl_t;

  localparam tio_ctrl_t CTRL_RST = '0;

  // clock block configuration
  typedef struct packed {
    logic       src_pin; // count edges of clk_pin, else bus clock
    logic [7:0] div;     // tick every div+1 source events
  } tio_cbcfg_t;

  localparam tio_cbcfg_t CB_RST = '0;

endpackage : tio_pkg

// ### design/tio_port.sv
// Purpose: timed i/o port with serializer, counter and clock blocks
// Assumes: inputs synchronous to clock; apb slave with one wait-free access
// Notes:   one port of parameter width; clock block 0 ticks every clock
//
// Overview of operation
// - port width is 1, 4, 8, 16 or 32 pins, moved as one unit
// - all pins of the port are inputs or all are outputs
// - port drives pins or samples them, optionally waiting on a pin condition
// - each software access to the port completes in one cycle
// - open collector per port: zero drives low, one floats
// - data passes through a shift stage and a transfer register
// - sixteen-bit counter controls when data moves to the transfer register
// - software may read the counter at any time
// - a transfer may be delayed until the counter reaches a set value
// - each transfer records the counter as a timestamp
// - an enabled link on shared pins disables the port pins
// - an enabled narrower port overrules this port on shared pins
// - unshared pins stay in use by the wider port
// - the port always transfers its full width
// - six clock blocks; block zero gives the reference clock
// - blocks other than zero run at programmable rates
// - a clock block can take a one-pin port as clock source
// - a pin-sourced clock block can divide the incoming clock
// - an incoming strobe qualifies input data
// - an outgoing strobe accompanies output data
// - after reset the port uses clock block zero
// - transfer ends become events sent to the scheduler
`timescale 1ns/1ps
`default_nettype none

module tio_port #(
  parameter int WIDTH = 32
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             rst,
  // apb slave
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  // pins
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_out,
  output logic      [WIDTH-1:0] pin_oe,
  input  wire logic             clk_pin,
  input  wire logic             strobe_in,
  output logic                  strobe_out,
  // pin sharing
  input  wire logic             link_en,
  input  wire logic [WIDTH-1:0] narrow_mask,
  // scheduler
  output logic                  port_event
);

  localparam int DW     = tio_pkg::DATA_W;
  localparam int SHIFTS = DW / WIDTH;
  localparam logic [5:0] LAST = 6'(SHIFTS - 1);
  localparam bit WIDTH_OK = (WIDTH == 1) || (WIDTH == 4) || (WIDTH == 8)
                         || (WIDTH == 16) || (WIDTH == 32);

  typedef enum logic [1:0] {TIO_IDLE, TIO_WAIT, TIO_SHIFT} tio_state_t;

  tio_pkg::tio_ctrl_t              ctrl;
  tio_pkg::tio_cbcfg_t             cb_cfg [tio_pkg::CB_N];
  logic [7:0]                      cb_cnt [tio_pkg::CB_N];
  logic [tio_pkg::CB_N-1:0]        cb_tick;
  logic [tio_pkg::CB_N-1:1]        cb_tick_hi;
  logic                            clk_pin_prev;
  logic [tio_pkg::CNT_W-1:0]       count;
  logic [tio_pkg::CNT_W-1:0]       time_tgt;
  logic [tio_pkg::CNT_W-1:0]       stamp;
  logic [WIDTH-1:0]                cond_val;
  logic [DW-1:0]                   tx_data;
  logic                            tx_full;
  logic [DW-1:0]                   rx_data;
  logic                            rx_valid;
  logic [DW-1:0]                   shreg;
  logic [5:0]                      nsh;
  logic [WIDTH-1:0]                pin_val;
  logic [WIDTH-1:0]                drv_val;
  tio_state_t                      st;
  logic                            tick;
  logic                            start_ok;
  logic                            beat;
  logic                            done;
  logic                            load;
  logic                            setup;
  logic                            ctrl_wr;
  logic                            wr_acc;
  logic                            rd_acc;
  logic [DW+WIDTH-1:0]             in_cat;

  // register index of a clock block offset, 0 when not a block
  function automatic logic [2:0] cb_index(input logic [7:0] a);
    logic [7:0] d;
    d = a - tio_pkg::OFS_CB;
    if (a >= tio_pkg::OFS_CB && d[1:0] == 2'h0 && d[7:2] >= 6'h01
        && d[7:2] < 6'(tio_pkg::CB_N))
      return d[4:2];
    return 3'h0;
  endfunction : cb_index

  // bus phase decode
  assign setup  = psel & ~penable;
  assign wr_acc = psel & penable & pready & pwrite;
  assign rd_acc = psel & penable & pready & ~pwrite;
  assign ctrl_wr = wr_acc && paddr == tio_pkg::OFS_CTRL; // reconfiguring aborts a transfer

  // selected clock block tick; block 0 ticks on every clock
  assign tick = (ctrl.cb_sel < 3'(tio_pkg::CB_N)) ? cb_tick[ctrl.cb_sel]
                                                  : 1'b0;

  // transfer may begin: time, pin condition and strobe all agree
  assign start_ok = (!ctrl.timed || count == time_tgt)
                 && (ctrl.dir_out || !ctrl.cond_en
                     || pin_in == cond_val)
                 && (ctrl.dir_out || !ctrl.strobe_in_en
                     || strobe_in);

  // one beat of the serializer on a port tick
  assign beat = tick && ctrl.enable && !link_en && !ctrl_wr
             && ((st == TIO_WAIT && start_ok)
              || (st == TIO_SHIFT && (ctrl.dir_out || !ctrl.strobe_in_en
                                      || strobe_in)));
  assign done = beat && nsh == LAST;
  assign load = st == TIO_IDLE && ctrl.enable && !link_en
             && ctrl.dir_out && tx_full && !ctrl_wr;
  assign in_cat = {pin_in, shreg};
  // pins show a beat's chunk together with its strobe
  assign drv_val = (beat && ctrl.dir_out) ? shreg[WIDTH-1:0] : pin_val;

  // clock block 0 follows the reference clock
  assign cb_tick = {cb_tick_hi, 1'b1};

  // clock blocks 1..5: source pin edge or bus clock, then divide
  always_ff @(posedge clock) begin
    if (rst) begin
      clk_pin_prev <= 1'b0;
      cb_tick_hi   <= '0;
      for (int k = 0; k < tio_pkg::CB_N; k++) begin
        cb_cnt[k] <= 8'h00;
      end
    end else begin
      clk_pin_prev <= clk_pin;
      for (int k = 1; k < tio_pkg::CB_N; k++) begin
        cb_tick_hi[k] <= 1'b0;
        if (!cb_cfg[k].src_pin || (clk_pin && !clk_pin_prev)) begin
          if (cb_cnt[k] >= cb_cfg[k].div) begin
            cb_cnt[k]     <= 8'h00;
            cb_tick_hi[k] <= 1'b1;
          end else begin
            cb_cnt[k] <= cb_cnt[k] + 8'h01;
          end
        end
      end
    end
  end
  // port counter advances per tick and wraps
  always_ff @(posedge clock) begin
    if (rst) begin
      count <= '0;
    end else if (tick) begin
      count <= count + 16'h0001;
    end
  end

  // serializer state machine
  always_ff @(posedge clock) begin
    if (rst) begin
      st      <= TIO_IDLE;
      shreg   <= '0;
      nsh     <= 6'h00;
      pin_val <= '0;
      stamp   <= '0;
    end else begin
      case (st)
        TIO_IDLE: begin
          nsh <= 6'h00;
          if (load) begin
            shreg <= tx_data;
            st    <= TIO_WAIT;
          end else if (ctrl.enable && !link_en && !ctrl.dir_out && !ctrl_wr) begin
            st <= TIO_WAIT;
          end
        end
        TIO_WAIT, TIO_SHIFT: begin
          if (!ctrl.enable || link_en || ctrl_wr) begin
            st <= TIO_IDLE;
          end else if (beat) begin
            if (st == TIO_WAIT) begin
              stamp <= count;
            end
            if (ctrl.dir_out) begin
              pin_val <= shreg[WIDTH-1:0];
              shreg   <= shreg >> WIDTH;
            end else begin
              shreg <= in_cat[DW+WIDTH-1:WIDTH];
            end
            nsh <= nsh + 6'h01;
            st  <= done ? TIO_IDLE : TIO_SHIFT;
          end
        end
        default: st <= TIO_IDLE;
      endcase
    end
  end

  // transfer register toward the core, set wins over read clear
  always_ff @(posedge clock) begin
    if (rst) begin
      rx_data  <= '0;
      rx_valid <= 1'b0;
    end else if (done && !ctrl.dir_out) begin
      rx_data  <= in_cat[DW+WIDTH-1:WIDTH];
      rx_valid <= 1'b1;
    end else if (rd_acc && paddr == tio_pkg::OFS_DATA) begin
      rx_valid <= 1'b0;
    end
  end

  // transfer register from the core, a write while full is ignored unless a load empties it in that cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      tx_data <= '0;
      tx_full <= 1'b0;
    end else if (wr_acc && paddr == tio_pkg::OFS_DATA
                 && (!tx_full || load)) begin
      tx_data <= pwdata;
      tx_full <= 1'b1;
    end else if (load) begin
      tx_full <= 1'b0;
    end
  end

  // pin drivers: direction, open collector, link and narrower port
  always_ff @(posedge clock) begin
    if (rst) begin
      pin_out <= '0;
      pin_oe  <= '0;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (!ctrl.enable || !ctrl.dir_out || link_en
            || narrow_mask[i]) begin
          pin_out[i] <= 1'b0;
          pin_oe[i]  <= 1'b0;
        end else if (ctrl.open_coll) begin
          pin_out[i] <= 1'b0;
          pin_oe[i]  <= !drv_val[i];
        end else begin
          pin_out[i] <= drv_val[i];
          pin_oe[i]  <= 1'b1;
        end
      end
    end
  end

  // outgoing strobe with each output beat, event at end of transfer
  always_ff @(posedge clock) begin
    if (rst) begin
      strobe_out <= 1'b0;
      port_event <= 1'b0;
    end else begin
      if (tick) begin
        strobe_out <= beat && ctrl.dir_out && ctrl.strobe_out_en;
      end
      port_event <= done;
    end
  end

  // software writes to control and clock block registers
  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl     <= tio_pkg::CTRL_RST;
      time_tgt <= '0;
      cond_val <= '0;
      for (int k = 0; k < tio_pkg::CB_N; k++) begin
        cb_cfg[k] <= tio_pkg::CB_RST;
      end
    end else if (wr_acc) begin
      case (paddr)
        tio_pkg::OFS_CTRL: ctrl     <= pwdata[$bits(ctrl)-1:0];
        tio_pkg::OFS_TIME: time_tgt <= pwdata[15:0];
        tio_pkg::OFS_COND: cond_val <= pwdata[WIDTH-1:0];
        default: begin
          if (cb_index(paddr) != 3'h0) begin
            cb_cfg[cb_index(paddr)] <= pwdata[8:0];
          end
        end
      endcase
    end
  end

  // apb answer: ready in the first access cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= setup;
      pslverr <= 1'b0;
      prdata  <= '0;
      if (setup) begin
        case (paddr)
          tio_pkg::OFS_CTRL:   prdata <= 32'(ctrl);
          tio_pkg::OFS_DATA:   prdata <= rx_data;
          tio_pkg::OFS_COND:   prdata <= 32'(cond_val);
          tio_pkg::OFS_TIME:   prdata <= 32'(time_tgt);
          tio_pkg::OFS_COUNT:  prdata <= 32'(count);
          tio_pkg::OFS_STAMP:  prdata <= 32'(stamp);
          tio_pkg::OFS_STATUS: begin
            prdata[tio_pkg::ST_RXV]  <= rx_valid;
            prdata[tio_pkg::ST_TXF]  <= tx_full;
            prdata[tio_pkg::ST_BUSY] <= st != TIO_IDLE;
          end
          default: begin
            if (cb_index(paddr) != 3'h0) begin
              prdata <= 32'(cb_cfg[cb_index(paddr)]);
            end else begin
              pslverr <= 1'b1;
            end
          end
        endcase
      end
    end
  end

  // checks
  AST_WIDTH: assert property (@(posedge clock) WIDTH_OK)
    else $error("illegal port width");

  AST_DIR: assert property (@(posedge clock) disable iff (rst)
    pin_oe != '0 |-> $past(ctrl.dir_out))
    else $error("input port drove its pins");

  AST_PREADY: assert property (@(posedge clock) disable iff (rst)
    setup |=> pready && !$past(pready))
    else $error("access not answered in one cycle");

  AST_OC: assert property (@(posedge clock) disable iff (rst)
    $past(ctrl.open_coll) |-> (pin_out & pin_oe) == '0)
    else $error("open collector drove a one");

  AST_CNT: assert property (@(posedge clock) disable iff (rst)
    !rst && tick |=> count == $past(count) + 16'h0001)
    else $error("counter missed a tick");

  AST_TIMED: assert property (@(posedge clock) disable iff (rst)
    beat && st == TIO_WAIT && ctrl.timed |-> count == time_tgt)
    else $error("timed transfer started early");

  AST_STAMP: assert property (@(posedge clock) disable iff (rst)
    beat && st == TIO_WAIT |=> stamp == $past(count))
    else $error("timestamp not taken");

  AST_LINK: assert property (@(posedge clock) disable iff (rst)
    link_en |=> pin_oe == '0)
    else $error("port drove pins under link");

  AST_NARROW: assert property (@(posedge clock) disable iff (rst)
    1'b1 |=> (pin_oe & $past(narrow_mask)) == '0)
    else $error("wider port drove a shared pin");

  AST_EVT: assert property (@(posedge clock) disable iff (rst)
    done |=> port_event ##1 !port_event)
    else $error("event not sent once");

  AST_RST: assert property (@(posedge clock)
    $past(rst) && !rst |-> ctrl.cb_sel == 3'h0)
    else $error("port not on clock block 0");

endmodule : tio_port

`default_nettype wire

// ### tb/tio_pins_model.sv
// Purpose: far-side hardware on the port pins: data source, strobe and pin clock
// Assumes: bench requests arrive as one-cycle pulses after a rising edge
// Notes:   released data lines show the inverse of the last value every cycle
`timescale 1ns/1ps
`default_nettype none

module tio_pins_model #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         clock,
  input  wire logic         rst,
  // requests from the bench
  input  wire logic         send,
  input  wire logic         slow,
  input  wire logic [31:0]  word,
  input  wire logic         clk_go,
  input  wire logic [7:0]   clk_edges,
  // pins towards the port
  output var  logic [W-1:0] pin_in,
  output var  logic         strobe_in,
  output var  logic         clk_pin,
  output logic              busy
);
  logic [4:0] idx;
  logic       active;
  logic       gap;
  logic [7:0] rem;
  logic [1:0] ph;

  // chunks lsb first, each qualified by strobe; slow mode leaves a gap
  always_ff @(posedge clock) begin
    if (rst) begin
      active    <= 1'b0;
      idx       <= '0;
      gap       <= 1'b0;
      strobe_in <= 1'b0;
      pin_in    <= '0;
    end else if (active && !(slow && gap)) begin
      pin_in    <= word[idx*W +: W];
      strobe_in <= 1'b1;
      idx       <= idx + 5'h01;
      gap       <= 1'b1;
      active    <= (idx != 5'(32/W-1));
    end else begin
      pin_in    <= ~pin_in; // released: inverse of the last value
      strobe_in <= 1'b0;
      gap       <= 1'b0;
      if (send) begin
        active <= 1'b1;
        idx    <= '0;
      end
    end
  end

  // application clock on the one-pin source, still and low between frames
  always_ff @(posedge clock) begin
    if (rst) begin
      rem     <= '0;
      ph      <= '0;
      clk_pin <= 1'b0;
    end else if (clk_go) begin
      rem <= clk_edges;
    end else if (rem != 8'h00) begin
      ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
      if (ph == 2'h2) begin
        clk_pin <= ~clk_pin;
        if (clk_pin) rem <= rem - 8'h01;
      end
    end
  end

  assign busy = active || (rem != 8'h00);
endmodule : tio_pins_model

`default_nettype wire

// ### tb/tb_top.sv
// Purpose: self-checking bench of the timed i/o port, eight pins wide
// Assumes: apb answers in the first access cycle; clock block 0 ticks each clock
// Notes:   drivers note expected results in queues, a watcher compares them
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  // clock, reset, apb and pins
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, clk_pin, strobe_in, strobe_out, port_event, p_busy;
  logic [7:0]  pin_in, pin_out, pin_oe, narrow_mask = 8'h00;
  logic        link_en = 1'b0, send = 1'b0, slow = 1'b0, clk_go = 1'b0;
  logic [31:0] word = 32'h0, seed = 32'h34, rdata, d, c1;
  logic [63:0] rd_q[$], ev_q[$], v;
  int          n_errors = 0, total_checks = 0, cyc = 0;

  always #50 clock = ~clock;

  tio_port #(.WIDTH(8)) i_dut (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .clk_pin(clk_pin), .strobe_in(strobe_in), .strobe_out(strobe_out), .link_en(link_en),
    .narrow_mask(narrow_mask), .port_event(port_event));

  tio_pins_model #(.W(8)) i_pins (.clock(clock), .rst(rst), .send(send), .slow(slow),
    .word(word), .clk_go(clk_go), .clk_edges(8'h08), .pin_in(pin_in),
    .strobe_in(strobe_in), .clk_pin(clk_pin), .busy(p_busy));

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task complete_run();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : complete_run

  // one apb transfer, request left standing for a back-to-back follower
  task apb(input logic [7:0] a, input logic w, input logic [31:0] wd, e, m, input logic err);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= wd;
    if (!w) rd_q.push_back({e, m});
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1);
    chk(n, 1);
    chk(32'(pslverr), 32'(err));
    rdata = prdata;
  endtask : apb

  task wr(input logic [7:0] a, input logic [31:0] wd);
    apb(a, 1'b1, wd, 32'h0, 32'h0, 1'b0);
  endtask : wr

  task rd(input logic [7:0] a, input logic [31:0] e, m);
    apb(a, 1'b0, 32'h0, e, m, 1'b0);
  endtask : rd

  task idle(input int c);
    psel    <= 1'b0;
    penable <= 1'b0;
    repeat (c) @(posedge clock);
  endtask : idle

  task pulse(input logic s, input logic g);
    send   <= s;
    clk_go <= g;
    @(posedge clock);
    send   <= 1'b0;
    clk_go <= 1'b0;
  endtask : pulse

  // wait until the far side is quiet and every transfer end was seen
  task settle();
    idle(1);
    do @(negedge clock); while (p_busy === 1'b1 || ev_q.size() != 0);
    @(posedge clock);
    repeat (3) @(posedge clock);
  endtask : settle

  task pinchk(input logic [31:0] e);
    idle(2);
    @(negedge clock);
    chk(32'(pin_oe), e);
    @(posedge clock);
  endtask : pinchk

  // watcher: oldest note against each read answer and transfer end
  always @(negedge clock) begin
    if (!rst && psel && penable && pready && !pwrite && rd_q.size() != 0) begin
      v = rd_q.pop_front();
      chk(prdata & v[31:0], v[63:32] & v[31:0]);
    end
    if (!rst && port_event === 1'b1) begin
      if (ev_q.size() == 0) chk(32'h1, 32'h0);
      else begin
        v = ev_q.pop_front();
        chk({15'h0, strobe_out, pin_oe, pin_out} & v[31:0], v[63:32] & v[31:0]);
      end
    end
  end

  // hang guard
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      complete_run();
    end
  end

  initial begin
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    rd(tio_pkg::OFS_CTRL, 32'h0, 32'hffffffff);
    rd(tio_pkg::OFS_STATUS, 32'h0, 32'hffffffff);
    rd(tio_pkg::OFS_STAMP, 32'h0, 32'hffffffff);
    apb(tio_pkg::OFS_CB, 1'b0, 32'h0, 32'h0, 32'hffffffff, 1'b1);
    for (int n = 1; n < tio_pkg::CB_N; n++) begin
      d = xs() & 32'h1ff;
      wr(tio_pkg::OFS_CB + 8'(4*n), d);
      rd(tio_pkg::OFS_CB + 8'(4*n), d, 32'hffffffff);
    end
    // output word with strobe, then open collector
    wr(tio_pkg::OFS_CTRL, 32'h13);
    d = xs();
    ev_q.push_back({15'h0, 1'b1, 8'hff, d[31:24], 32'h1ffff});
    wr(tio_pkg::OFS_DATA, d);
    settle();
    wr(tio_pkg::OFS_CTRL, 32'h07);
    d = xs();
    ev_q.push_back({15'h0, 1'b0, ~d[31:24], 8'h00, 32'h1ffff});
    wr(tio_pkg::OFS_DATA, d);
    settle();
    narrow_mask <= 8'h0f;
    pinchk(32'(~d[31:24] & 8'hf0));
    link_en <= 1'b1;
    pinchk(32'h0);
    link_en     <= 1'b0;
    narrow_mask <= 8'h00;
    // timed output
    wr(tio_pkg::OFS_CTRL, 32'h43);
    rd(tio_pkg::OFS_COUNT, 32'h0, 32'h0);
    c1 = rdata;
    rd(tio_pkg::OFS_COUNT, 32'h0, 32'h0);
    chk((rdata - c1) & 32'hffff, 32'h2);
    c1 = (rdata + 32'd60) & 32'hffff;
    wr(tio_pkg::OFS_TIME, c1);
    d = xs();
    ev_q.push_back({15'h0, 1'b0, 8'hff, d[31:24], 32'h1ffff});
    wr(tio_pkg::OFS_DATA, d);
    settle();
    rd(tio_pkg::OFS_STAMP, c1, 32'hffffffff);
    // input words with strobe and start condition, slow then prompt
    for (int k = 0; k < 2; k++) begin
      word <= xs();
      slow <= (k == 0);
      idle(1);
      wr(tio_pkg::OFS_COND, 32'(word[7:0]));
      wr(tio_pkg::OFS_CTRL, 32'h29);
      ev_q.push_back({32'h0, 32'hff00});
      idle(1);
      pulse(1'b1, 1'b0);
      settle();
      rd(tio_pkg::OFS_DATA, word, 32'hffffffff);
    end
    // clock block 1 from the clock pin, divided by two
    wr(tio_pkg::OFS_CB + 8'h04, 32'h101);
    wr(tio_pkg::OFS_CTRL, 32'h83);
    rd(tio_pkg::OFS_COUNT, 32'h0, 32'h0);
    c1 = rdata;
    idle(1);
    pulse(1'b0, 1'b1);
    settle();
    rd(tio_pkg::OFS_COUNT, 32'h0, 32'h0);
    chk((rdata - c1) & 32'hffff, 32'h4);
    idle(2);
    complete_run();
  end
endmodule : tb_top

`default_nettype wire
